// ---- adc_conversion_start_n_interface.sv ----
// What this block does
// - Host drives two channel-select inputs; device decodes them to pick an input.
// - Code high bit first: 00 input 0 up to 11 input 3.
// - Result bus lines stay high impedance while a conversion runs.
// - Device select is active low.
// - Read strobe is active low; data is driven while it and device select are low.
// - Conversion clock is divided by 1, 2, 4 or 8 from two select pins.
// - Falling edge of conversion start enters hold mode at once.
// - Rising edge of conversion start latches the channel for next conversion.
// - Busy rises when a conversion begins, falls when the result is ready.
// - Busy drops after the 18th divided clock period of a conversion.
// - Width select low gives a 16-bit bus, high an 8-bit bus.
// - Width select low: result bits 15..0 on bus lines 15..0.
// - Width select high: bits 15..8 on lines 7..0, changeable during read.
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_start_n_interface
  import adc_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rstn_i,
  // Host control pins
  input  wire logic                     channel_select_low_bit_i,
  input  wire logic                     channel_select_high_bit_i,
  input  wire logic [DIV_SEL_WIDTH-1:0] clock_divide_select_i,
  input  wire logic                     conversion_start_n_i,
  input  wire logic                     chip_select_n_i,
  input  wire logic                     read_n_i,
  input  wire logic                     byte_mode_i,
  // Host status and data pins
  output logic                          busy_o,
  output logic [RESULT_WIDTH-1:0]       parallel_result_bus_o,
  output logic [RESULT_WIDTH-1:0]       parallel_result_bus_oe_o,
  // Analog front end
  input  wire logic                     comparator_i,
  output logic                          hold_o,
  output logic [CHAN_WIDTH-1:0]         mux_channel_o,
  output logic [RESULT_WIDTH-1:0]       dac_code_o
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  core_type r;
  core_type next_r;
  logic     tick;
  logic     conversion_start_n_fall;
  logic     conversion_start_n_rise;
  logic     conversion_start_n_start;
  logic     read_active;

  assign conversion_start_n_fall = r.conversion_start_n_prev && !conversion_start_n_i;
  assign conversion_start_n_rise = !r.conversion_start_n_prev && conversion_start_n_i;
  // Falling start edges inside a conversion are ignored and must not move the
  // divider phase either
  assign conversion_start_n_start = conversion_start_n_fall && r.state == ST_SAMPLE;

  conversion_start_n_clock_divider u_divider (
    .clk_i                 (clk_i),
    .rstn_i                (rstn_i),
    .clock_divide_select_i (clock_divide_select_i),
    .restart_i             (conversion_start_n_start),
    .tick_o                (tick)
  );

  always_comb begin
    next_r = r;
    next_r.conversion_start_n_prev = conversion_start_n_i;
    // Channel for the next conversion is taken on the release of start
    if (conversion_start_n_rise) begin
      next_r.channel = {channel_select_high_bit_i,
                        channel_select_low_bit_i};
    end
    unique case (r.state)
      ST_SAMPLE: begin
        if (conversion_start_n_fall) begin
          next_r.state   = ST_CONVERT;
          next_r.periods = '0;
          next_r.sar     = '0;
          next_r.trial   = TRIAL_MSB;
        end
      end
      ST_CONVERT: begin
        if (tick) begin
          next_r.periods = r.periods + 5'h1;
          // One result bit decided per period, most significant first
          if (r.periods < SAR_LAST_PERIOD) begin
            if (comparator_i) begin
              next_r.sar = r.sar | r.trial;
            end
            next_r.trial = r.trial >> 1;
          end
          if (r.periods + 5'h1 == CONVERSION_START_N_PERIODS) begin
            next_r.state  = ST_SAMPLE;
            next_r.result = r.sar;
          end
        end
      end
    endcase
    // Byte select is not latched; the lanes follow it every cycle
    if (byte_mode_i) begin
      next_r.bus_data = {{BYTE_WIDTH{1'b0}},
                         r.result[RESULT_WIDTH-1 -: BYTE_WIDTH]};
    end else begin
      next_r.bus_data = r.result;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r.state     <= ST_SAMPLE;
      r.conversion_start_n_prev <= 1'b1;
      r.channel   <= CHAN_RESET;
      r.periods   <= '0;
      r.sar       <= RESULT_RESET;
      r.trial     <= RESULT_RESET;
      r.result    <= RESULT_RESET;
      r.bus_data  <= RESULT_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Drivers open only for a selected, active read outside a conversion
  assign read_active = !chip_select_n_i && !read_n_i
                       && r.state == ST_SAMPLE;

  always_comb begin
    if (!read_active) begin
      parallel_result_bus_oe_o = OE_NONE;
    end else if (byte_mode_i) begin
      parallel_result_bus_oe_o = OE_BYTE;
    end else begin
      parallel_result_bus_oe_o = OE_FULL;
    end
  end

  assign parallel_result_bus_o = r.bus_data;
  assign busy_o                = (r.state == ST_CONVERT);
  assign hold_o                = (r.state == ST_CONVERT);
  assign mux_channel_o         = r.channel;
  assign dac_code_o            = r.sar | r.trial;

  sequence conversion_start_n_begin_seq;
    r.state == ST_SAMPLE && conversion_start_n_fall;
  endsequence

  sequence conversion_start_n_hold_seq;
    busy_o && hold_o;
  endsequence

  chk_bus_float: assert property (
    busy_o |-> parallel_result_bus_oe_o == OE_NONE)
    else $error("result bus driven during a conversion");

  chk_read_full: assert property (
    (!chip_select_n_i && !read_n_i && !busy_o && !byte_mode_i)
    |-> parallel_result_bus_oe_o == OE_FULL)
    else $error("16-bit read does not drive all lines");

  chk_read_byte: assert property (
    (!chip_select_n_i && !read_n_i && !busy_o && byte_mode_i)
    |-> parallel_result_bus_oe_o == OE_BYTE)
    else $error("8-bit read does not drive the low lanes only");

  chk_hold_entry: assert property (
    conversion_start_n_begin_seq |=> conversion_start_n_hold_seq)
    else $error("start edge did not enter hold with busy");

  chk_channel_latch: assert property (
    conversion_start_n_rise |=> mux_channel_o == {$past(channel_select_high_bit_i),
                                    $past(channel_select_low_bit_i)})
    else $error("channel not latched on start release");

  chk_busy_end: assert property (
    (busy_o && tick && r.periods == 5'h11) |=> !busy_o)
    else $error("busy not dropped after the 18th period");

  chk_busy_hold: assert property (
    (busy_o && !(tick && r.periods == 5'h11)) |=> busy_o)
    else $error("busy dropped before the conversion ended");

  chk_word_order: assert property (
    (!busy_o && !byte_mode_i && $stable(r.result)) |=>
    parallel_result_bus_o == $past(r.result))
    else $error("16-bit result not in matching bit order");

  chk_byte_order: assert property (
    (!busy_o && byte_mode_i && $stable(r.result)) |=>
    parallel_result_bus_o == {8'h00, $past(r.result[15:8])})
    else $error("upper result byte not on the low lanes");

  chk_busy_rise: assert property (
    (!busy_o && !conversion_start_n_fall) |=> !busy_o)
    else $error("busy rose without a start edge");

  chk_channel_keep: assert property (
    !conversion_start_n_rise |=> $stable(mux_channel_o))
    else $error("channel changed without a start release");

  chk_period_step: assert property (
    (busy_o && !tick) |=> r.periods == $past(r.periods))
    else $error("period count moved without a divided tick");

  chk_first_trial: assert property (
    conversion_start_n_begin_seq |=> dac_code_o == TRIAL_MSB)
    else $error("conversion did not begin at the top trial bit");

  chk_idle_float: assert property (
    (chip_select_n_i || read_n_i) |-> parallel_result_bus_oe_o == OE_NONE)
    else $error("result bus driven without select and read");

endmodule : adc_conversion_start_n_interface

`default_nettype wire

// ---- adc_pkg.sv ----
`timescale 1ns/1ps
`default_nettype none

package adc_pkg;

  localparam int          RESULT_WIDTH     = 16;
  localparam int          BYTE_WIDTH       = 8;
  localparam int          CHAN_WIDTH       = 2;
  localparam int          DIV_SEL_WIDTH    = 2;
  localparam int          DIV_COUNT_WIDTH  = 3;
  localparam int          PERIOD_WIDTH     = 5;
  // Clock periods per conversion; busy drops after the last one
  localparam logic [4:0]  CONVERSION_START_N_PERIODS     = 5'h12;
  // First period in which no result bit is decided
  localparam logic [4:0]  SAR_LAST_PERIOD  = 5'h10;
  localparam logic [15:0] TRIAL_MSB        = 16'h8000;
  localparam logic [15:0] RESULT_RESET     = 16'h0000;
  localparam logic [15:0] OE_FULL          = 16'hffff;
  localparam logic [15:0] OE_BYTE          = 16'h00ff;
  localparam logic [15:0] OE_NONE          = 16'h0000;
  localparam logic [1:0]  CHAN_RESET       = 2'h0;

  typedef enum logic [0:0] {
    ST_SAMPLE  = 1'h0,
    ST_CONVERT = 1'h1
  } conversion_start_n_state_type;

  typedef struct packed {
    conversion_start_n_state_type state;
    logic           conversion_start_n_prev;
    logic [1:0]     channel;
    logic [4:0]     periods;
    logic [15:0]    sar;
    logic [15:0]    trial;
    logic [15:0]    result;
    logic [15:0]    bus_data;
  } core_type;

  typedef struct packed {
    logic [2:0] count;
    logic       tick;
  } div_type;

endpackage : adc_pkg

module conversion_start_n_clock_divider
  import adc_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rstn_i,
  // Control
  input  wire logic [DIV_SEL_WIDTH-1:0] clock_divide_select_i,
  input  wire logic                     restart_i,
  // Divided period marker
  output logic                          tick_o
);

  div_type                    r;
  div_type                    next_r;
  logic [DIV_COUNT_WIDTH-1:0] limit;
  logic [DIV_COUNT_WIDTH-1:0] gap;
  logic [DIV_SEL_WIDTH-1:0]   sel_d;
  logic                       restart_d;
  logic                       settled;

  // Binary code: 0 -> /1, 1 -> /2, 2 -> /4, 3 -> /8
  assign limit = DIV_COUNT_WIDTH'((4'h1 << clock_divide_select_i) - 4'h1);

  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (restart_i) begin
      next_r.count = '0;
    end else if (r.count >= limit) begin
      next_r.count = '0;
      next_r.tick  = 1'b1;
    end else begin
      next_r.count = r.count + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Tick is given in the cycle its period ends; the register copy only
  // serves the period check below
  assign tick_o = next_r.tick;

  // Cycles since the previous tick, for checking only; a restart acts
  // like a registered tick, one cycle late
  always_ff @(posedge clk_i) begin
    if (!rstn_i || restart_d || r.tick) begin
      gap <= '0;
    end else begin
      gap <= gap + 3'h1;
    end
  end

  // A period is only judged when the select held since the last tick
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      restart_d <= 1'b0;
      sel_d     <= '0;
      settled   <= 1'b0;
    end else begin
      restart_d <= restart_i;
      sel_d     <= clock_divide_select_i;
      if (clock_divide_select_i != sel_d) begin
        settled <= 1'b0;
      end else if (r.tick) begin
        settled <= 1'b1;
      end
    end
  end

  chk_tick_ratio: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (r.tick && settled && !$past(restart_i)
     && $stable(clock_divide_select_i)
     && $past(r.tick) == 1'b0 && gap != '0) |-> gap == limit)
    else $error("divided period length does not match divider select");

endmodule : conversion_start_n_clock_divider

`default_nettype wire

// ---- host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module host_model
  import adc_pkg::*;
(
  // Clock and device outputs
  input  wire logic        clk_i,
  input  wire logic [15:0] bus_i,
  input  wire logic [15:0] oe_i,
  // Device control pins
  output logic             chan_lo_o,
  output logic             chan_hi_o,
  output logic [1:0]       div_o,
  output logic             start_n_o,
  output logic             cs_n_o,
  output logic             rd_n_o,
  output logic             byte_o
);
  // Start, select and read idle high (inactive) through reset
  initial begin
    {chan_hi_o, chan_lo_o, div_o, byte_o} = 5'h00;
    {start_n_o, cs_n_o, rd_n_o} = 3'h7;
  end

  task automatic set_rd(input logic lvl);
    @(negedge clk_i);
    rd_n_o = lvl;
  endtask : set_rd

  task automatic set_cs(input logic lvl);
    @(negedge clk_i);
    cs_n_o = lvl;
  endtask : set_cs

  task automatic set_byte(input logic lvl);
    @(negedge clk_i);
    byte_o = lvl;
  endtask : set_byte

  task automatic pulse_start;
    @(negedge clk_i);
    start_n_o = 1'b0;
    @(negedge clk_i);
    start_n_o = 1'b1;
  endtask : pulse_start

  task automatic start(input logic [1:0] chan, input logic [1:0] div);
    @(negedge clk_i);
    {chan_hi_o, chan_lo_o} = chan;
    div_o = div;
    cs_n_o = 1'b0;
    start_n_o = 1'b1;
    pulse_start();
  endtask : start

  // Caller waits for busy low first
  task automatic read(input logic b, output logic [15:0] d,
                      output logic [15:0] oe);
    @(negedge clk_i);
    byte_o = b;
    rd_n_o = 1'b0;
    repeat (2) @(negedge clk_i);
    d = bus_i;
    oe = oe_i;
    rd_n_o = 1'b1;
    repeat (24) @(negedge clk_i);
  endtask : read
endmodule : host_model

`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import adc_pkg::*;

  typedef struct packed {
    logic [1:0]  chan;
    logic [1:0]  div;
    logic        bsel;
    logic [15:0] target;
  } row_type;

  localparam row_type ROWS [4] = '{
    '{2'h0, 2'h0, 1'b0, 16'hffff}, '{2'h1, 2'h1, 1'b1, 16'ha55a},
    '{2'h2, 2'h2, 1'b0, 16'h0001}, '{2'h3, 2'h3, 1'b1, 16'h8000}};

  logic clk_i, rstn_i, cmp, lo, hi, st_n, cs_n, rd_n, bsel, busy, hold;
  logic [1:0]  div, mux;
  logic [15:0] target, pat, dac, bus_d, oe_d, wire_v, data, oe, exp_oe;
  int          busy_cnt, n_errors, cmp_count;

  // Undriven lines show a pattern that flips every cycle
  assign wire_v = (oe_d & bus_d) | (~oe_d & pat);
  assign cmp = (dac <= target);

  adc_conversion_start_n_interface u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
    .channel_select_low_bit_i(lo), .channel_select_high_bit_i(hi),
    .clock_divide_select_i(div), .conversion_start_n_i(st_n),
    .chip_select_n_i(cs_n), .read_n_i(rd_n), .byte_mode_i(bsel),
    .busy_o(busy), .parallel_result_bus_o(bus_d),
    .parallel_result_bus_oe_o(oe_d), .comparator_i(cmp), .hold_o(hold),
    .mux_channel_o(mux), .dac_code_o(dac));

  host_model u_host (.clk_i(clk_i), .bus_i(wire_v), .oe_i(oe_d),
    .chan_lo_o(lo), .chan_hi_o(hi), .div_o(div), .start_n_o(st_n),
    .cs_n_o(cs_n), .rd_n_o(rd_n), .byte_o(bsel));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  initial pat = 16'h5a5a;
  always @(posedge clk_i) begin
    pat <= ~pat;
    if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk_n(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      n_errors++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_n

  task automatic wait_busy;
    for (int i = 0; i < 8 && busy !== 1'b1; i++) @(negedge clk_i);
    chk16({15'h0, hold}, 16'h0001);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk_i);
  endtask : wait_busy

  task automatic complete_run;
    $display("Errors %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  initial begin
    #(20000 * 8);
    n_errors++;
    complete_run();
  end

  initial begin
    {rstn_i, target, busy_cnt, n_errors, cmp_count} = '0;
    repeat (5) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk16({busy, hold, mux, dac[11:0]}, 16'h0000);
    chk16(oe_d, OE_NONE);
    for (int r = 0; r < 4; r++) begin
      target = ROWS[r].target;
      busy_cnt = 0;
      u_host.start(ROWS[r].chan, ROWS[r].div);
      wait_busy();
      chk_n(busy_cnt, 18 << ROWS[r].div);
      chk16({14'h0, mux}, {14'h0, ROWS[r].chan});
      u_host.read(ROWS[r].bsel, data, oe);
      exp_oe = ROWS[r].bsel ? OE_BYTE : OE_FULL;
      chk16(oe, exp_oe);
      chk16(data & exp_oe, ROWS[r].bsel ? {8'h00, target[15:8]} : target);
      chk16(oe_d, OE_NONE);
    end
    // Read and second start while converting
    target = 16'h3c5a;
    busy_cnt = 0;
    u_host.start(2'h2, 2'h0);
    repeat (3) @(negedge clk_i);
    u_host.set_rd(1'b0);
    @(negedge clk_i);
    chk16(oe_d, OE_NONE);
    u_host.set_rd(1'b1);
    u_host.pulse_start();
    wait_busy();
    chk_n(busy_cnt, 18);
    // Width switch while read stays low
    u_host.set_byte(1'b0);
    u_host.set_rd(1'b0);
    @(negedge clk_i);
    chk16(wire_v, 16'h3c5a);
    u_host.set_byte(1'b1);
    @(negedge clk_i);
    chk16({oe_d[15:8], wire_v[7:0]}, 16'h003c);
    u_host.set_cs(1'b1);
    @(negedge clk_i);
    chk16(oe_d, OE_NONE);
    u_host.set_rd(1'b1);
    // Reset in mid conversion: back to idle, nothing restarts
    u_host.start(2'h1, 2'h0);
    repeat (4) @(negedge clk_i);
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk16({busy, hold, mux, dac[11:0]}, 16'h0000);
    repeat (8) @(negedge clk_i);
    busy_cnt = 0;
    u_host.start(2'h3, 2'h1);
    wait_busy();
    chk_n(busy_cnt, 36);
    chk16({14'h0, mux}, 16'h0003);
    u_host.read(1'b0, data, oe);
    chk16(data, 16'h3c5a);
    complete_run();
  end
endmodule : testbench

`default_nettype wire
